// File: dsr_reset_gen.sv
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - Reset output asserted at power-up and while either supply reports undervoltage.
// - After supplies recover, reset stays asserted at least 140 ms.
// - Low manual reset request on a connected pin asserts reset immediately, whatever the supplies.
// - After manual request releases with good supplies, release no sooner than 140 ms.
// - Output build option: active-high, active-low push-pull, or open-drain active-low.
// - Open-drain: pull low when asserted, float otherwise; system supplies pull-up.
// - Adjustable-input undervoltage (300 mV reference) starts same reset sequence.
// - Manual reset request reads inactive high when left unconnected.
// - Brief dips on monitored inputs are ignored; only persistent ones reset.
module dsr_reset_gen #(
   parameter dsr_pkg::dsr_out_mode_t OUT_MODE = dsr_pkg::DSR_OUT_LOW,
   parameter int RELEASE_CYC = dsr_pkg::RELEASE_CYC,
   parameter int FILT_CYC = dsr_pkg::GLITCH_CYC
) (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic supply_uv,
   input wire logic adj_uv,
   input wire logic manual_reset_req_n,
   input wire logic manual_reset_conn,
   output logic rst_out,
   output logic rst_out_oe,
   output logic rst_asserted
);
   localparam int RW = $clog2(RELEASE_CYC + 1);
   localparam logic [RW-1:0] RLAST = RW'(RELEASE_CYC - 1);
   localparam int FW = $clog2(FILT_CYC + 2);
   localparam logic [FW-1:0] FFULL = FW'(FILT_CYC + 1);

   // one step of the release count; the quiet counter below must move in lockstep
   function automatic logic [RW-1:0] step_up(input logic [RW-1:0] v);
      return v + RW'(1);
   endfunction

   // one step of a raw-input run length, saturating where the filter would accept
   function automatic logic [FW-1:0] run_step(input logic [FW-1:0] v);
      return (v == FFULL) ? v : v + FW'(1);
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   logic supply_uv_f;
   logic adj_uv_f;
   logic manual_n;
   logic cause;
   logic [RW-1:0] cnt_r;
   logic [RW-1:0] cnt_nxt;
   dsr_pkg::dsr_state_t state_r;
   dsr_pkg::dsr_state_t state_nxt;

   dsr_filter #(.FILT_CYC(FILT_CYC)) u_supply_filt (
      .clk(clk),
      .reset_n(reset_n),
      .raw_uv(supply_uv),
      .uv_r(supply_uv_f)
   );

   dsr_filter #(.FILT_CYC(FILT_CYC)) u_adj_filt (
      .clk(clk),
      .reset_n(reset_n),
      .raw_uv(adj_uv),
      .uv_r(adj_uv_f)
   );

   // an open pin behaves as if pulled up
   assign manual_n = manual_reset_req_n || !manual_reset_conn;
   // manual request bypasses filtering so it acts at once
   assign cause = supply_uv_f || adj_uv_f || !manual_n;

   ////////////////////////////////////////////////////////////////////////////
   always_comb begin
      state_nxt = state_r;
      cnt_nxt = cnt_r;
      unique case (state_r)
         dsr_pkg::DSR_ST_HOLD: begin
            if (cause) begin
               cnt_nxt = '0;
            end else if (cnt_r == RLAST) begin
               state_nxt = dsr_pkg::DSR_ST_RUN;
            end else begin
               cnt_nxt = step_up(cnt_r);
            end
         end
         dsr_pkg::DSR_ST_RUN: begin
            if (cause) begin
               state_nxt = dsr_pkg::DSR_ST_HOLD;
               cnt_nxt = '0;
            end
         end
         default: begin
            state_nxt = dsr_pkg::DSR_ST_HOLD;
            cnt_nxt = '0;
         end
      endcase
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         state_r <= dsr_pkg::DSR_ST_HOLD;
         cnt_r <= '0;
      end else begin
         state_r <= state_nxt;
         cnt_r <= cnt_nxt;
      end
   end

   // manual request asserts combinationally so it is seen in the same cycle
   assign rst_asserted = (state_r != dsr_pkg::DSR_ST_RUN) || !manual_n;

   ////////////////////////////////////////////////////////////////////////////
   // open-drain only ever drives low; the released level comes from the board
   always_comb begin
      unique case (OUT_MODE)
         dsr_pkg::DSR_OUT_HIGH: begin
            rst_out = rst_asserted;
            rst_out_oe = 1'b1;
         end
         dsr_pkg::DSR_OUT_OPEN_DRAIN: begin
            rst_out = 1'b0;
            rst_out_oe = rst_asserted;
         end
         default: begin
            rst_out = !rst_asserted;
            rst_out_oe = 1'b1;
         end
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////
   // checking aids only: nothing here feeds the reset output
   logic [RW-1:0] quiet_r;
   logic [FW-1:0] supply_run_r;
   logic [FW-1:0] adj_run_r;

   // independent count of cause-free cycles, saturating at the release point
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         quiet_r <= '0;
      end else if (cause) begin
         quiet_r <= '0;
      end else if (quiet_r != RLAST) begin
         quiet_r <= step_up(quiet_r);
      end
   end

   // consecutive high samples of each raw undervoltage input
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         supply_run_r <= '0;
      end else if (!supply_uv) begin
         supply_run_r <= '0;
      end else begin
         supply_run_r <= run_step(supply_run_r);
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         adj_run_r <= '0;
      end else if (!adj_uv) begin
         adj_run_r <= '0;
      end else begin
         adj_run_r <= run_step(adj_run_r);
      end
   end

   sequence cause_gone_s;
      !cause;
   endsequence

   // manual pin let go while both supplies are good
   sequence manual_let_go_s;
      $rose(manual_reset_req_n) && manual_reset_conn && !supply_uv_f && !adj_uv_f;
   endsequence

   // a cause that the filters have accepted
   sequence supply_taken_s;
      $rose(supply_uv_f);
   endsequence

   sequence adj_taken_s;
      $rose(adj_uv_f);
   endsequence

   ////////////////////////////////////////////////////////////////////////////
   no_early_release_a: assert property (@(posedge clk) disable iff (!reset_n)
      $fell(rst_asserted) |-> $past(quiet_r) == RLAST)
      else $error("reset released before full quiet delay");
   power_up_hold_a: assert property (@(posedge clk)
      $rose(reset_n) |-> rst_asserted ##1 rst_asserted)
      else $error("reset not held after power-on");
   manual_immediate_a: assert property (@(posedge clk) disable iff (!reset_n)
      !manual_reset_req_n && manual_reset_conn |-> rst_asserted)
      else $error("manual request did not assert reset");
   manual_hold_a: assert property (@(posedge clk) disable iff (!reset_n)
      manual_let_go_s |-> rst_asserted ##1 rst_asserted)
      else $error("reset dropped right after manual request released");
   supply_holds_a: assert property (@(posedge clk) disable iff (!reset_n)
      supply_uv_f |=> rst_asserted)
      else $error("reset not asserted under supply undervoltage");
   adj_holds_a: assert property (@(posedge clk) disable iff (!reset_n)
      adj_uv_f |=> rst_asserted)
      else $error("reset not asserted under adjustable undervoltage");
   restart_delay_a: assert property (@(posedge clk) disable iff (!reset_n)
      cause |=> cnt_r == '0 && state_r == dsr_pkg::DSR_ST_HOLD)
      else $error("delay not restarted by returning cause");
   unused_pin_a: assert property (@(posedge clk) disable iff (!reset_n)
      !manual_reset_conn && !supply_uv_f && !adj_uv_f && state_r == dsr_pkg::DSR_ST_RUN
      |-> !rst_asserted)
      else $error("unconnected manual input caused reset");
   od_float_a: assert property (@(posedge clk) disable iff (!reset_n)
      OUT_MODE == dsr_pkg::DSR_OUT_OPEN_DRAIN |-> !rst_out && rst_out_oe == rst_asserted)
      else $error("open drain output drove high or wrong enable");
   push_pull_a: assert property (@(posedge clk) disable iff (!reset_n)
      OUT_MODE != dsr_pkg::DSR_OUT_OPEN_DRAIN
      |-> rst_out_oe && rst_out == (rst_asserted ^ (OUT_MODE == dsr_pkg::DSR_OUT_LOW)))
      else $error("push-pull output level or enable wrong");
   glitch_reject_a: assert property (@(posedge clk) disable iff (!reset_n)
      supply_taken_s |-> supply_run_r == FFULL)
      else $error("brief supply dip accepted");
   adj_glitch_a: assert property (@(posedge clk) disable iff (!reset_n)
      adj_taken_s |-> adj_run_r == FFULL)
      else $error("brief adjustable dip accepted");
   release_after_a: assert property (@(posedge clk) disable iff (!reset_n)
      cause_gone_s ##1 $fell(rst_asserted) |-> $past(quiet_r, 2) == RLAST - RW'(1))
      else $error("release timing after manual request wrong");
endmodule
`default_nettype wire

// File: dsr_pkg.sv
`default_nettype none
package dsr_pkg;
   localparam int CLK_HZ = 40_000_000;
   localparam int RELEASE_MS = 140;
   localparam int RELEASE_CYC = (RELEASE_MS * (CLK_HZ / 1000));
   localparam int GLITCH_US = 20;
   localparam int GLITCH_CYC = (GLITCH_US * (CLK_HZ / 1_000_000));
   localparam int REF_MV = 300;
   typedef enum logic [1:0] {
      DSR_OUT_HIGH = 2'h0,
      DSR_OUT_LOW = 2'h1,
      DSR_OUT_OPEN_DRAIN = 2'h2
   } dsr_out_mode_t;
   typedef enum logic [1:0] {
      DSR_ST_HOLD = 2'h1,
      DSR_ST_RUN = 2'h2
   } dsr_state_t;
endpackage
`default_nettype wire

// File: dsr_filter.sv
`timescale 1ns/1ps
`default_nettype none
// a cause is accepted only after it persists for the full count; release is immediate
module dsr_filter #(
   parameter int FILT_CYC = dsr_pkg::GLITCH_CYC
) (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic raw_uv,
   output logic uv_r
);
   localparam int CW = $clog2(FILT_CYC + 1);
   localparam logic [CW-1:0] CMAX = CW'(FILT_CYC);
   logic [CW-1:0] cnt_r;

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         cnt_r <= '0;
      end else if (!raw_uv) begin
         cnt_r <= '0;
      end else if (cnt_r != CMAX) begin
         cnt_r <= cnt_r + CW'(1);
      end
   end

   // power-on counts as undervoltage until proven otherwise
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         uv_r <= 1'b1;
      end else begin
         uv_r <= raw_uv && ((cnt_r == CMAX) || uv_r);
      end
   end
endmodule
`default_nettype wire

// File: dsr_rx.sv
`timescale 1ns/1ps
`default_nettype none
module dsr_rx #(
   parameter bit ACT_HIGH = 1'b0
) (
   input wire logic pin_drv,
   input wire logic pin_oe,
   output logic in_reset
);
   logic pin_level;
   // a released open-drain pin floats up through the system pull-up
   assign pin_level = pin_oe ? pin_drv : 1'b1;
   assign in_reset = (pin_level == ACT_HIGH);
endmodule
`default_nettype wire

// File: dual_supply_reset_generator_tb.sv
`timescale 1ns/1ps
`default_nettype none
module dual_supply_reset_generator_tb;
   localparam int RC = 20;
   localparam int FC = 3;
   logic clk = 1'b0;
   logic reset_n = 1'b0;
   logic supply_uv = 1'b0;
   logic adj_uv = 1'b0;
   logic manual_reset_req_n = 1'b1;
   logic mr_conn = 1'b1;
   logic [2:0] drv;
   logic [2:0] oe;
   logic [2:0] in_rst;
   logic [2:0] asrt;
   int errors = 0;
   int comparisons = 0;
   int n;
   genvar g;
   // one instance per output build option, each with its own receiver
   for (g = 0; g < 3; g++) begin : g_mode
      dsr_reset_gen #(.OUT_MODE(dsr_pkg::dsr_out_mode_t'(g)), .RELEASE_CYC(RC),
         .FILT_CYC(FC)) i_dsr_reset_gen (.clk(clk), .reset_n(reset_n),
         .supply_uv(supply_uv), .adj_uv(adj_uv), .manual_reset_req_n(manual_reset_req_n),
         .manual_reset_conn(mr_conn), .rst_out(drv[g]), .rst_out_oe(oe[g]),
         .rst_asserted(asrt[g]));
      dsr_rx #(.ACT_HIGH(g == 0)) i_dsr_rx (.pin_drv(drv[g]), .pin_oe(oe[g]),
         .in_reset(in_rst[g]));
   end
   initial begin
      forever #12.5 clk = ~clk;
   end
   ////////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [2:0] seen, input logic [2:0] exp);
      comparisons++;
      if (seen !== exp) begin
         errors++;
         $display("mismatch t=%0t seen=%0h exp=%0h", $time, seen, exp);
      end
   endtask
   task automatic cyc(input int k);
      repeat (k) @(posedge clk);
   endtask
   // counts cycles from the cause dropping until every receiver leaves reset
   task automatic rel(input int lo, input int hi);
      n = 0;
      while (in_rst !== 3'h0 && n < hi + 5) begin
         @(negedge clk);
         n++;
      end
      chk({2'h0, (n >= lo) && (n <= hi)}, 3'h1);
   endtask
   task automatic t_manual;
      @(posedge clk);
      manual_reset_req_n <= 1'b0;
      @(negedge clk);
      chk(in_rst, 3'h7);
      chk(asrt, 3'h7);
      @(posedge clk);
      manual_reset_req_n <= 1'b1;
      cyc(RC / 2);
      manual_reset_req_n <= 1'b0;
      @(posedge clk);
      manual_reset_req_n <= 1'b1;
      rel(RC, RC + 2);
   endtask
   task automatic t_uv(input bit adj);
      @(posedge clk);
      adj_uv <= adj;
      supply_uv <= !adj;
      cyc(FC);
      adj_uv <= 1'b0;
      supply_uv <= 1'b0;
      repeat (6) begin
         @(negedge clk);
         chk(in_rst, 3'h0);
      end
      @(posedge clk);
      adj_uv <= adj;
      supply_uv <= !adj;
      cyc(FC + 3);
      @(negedge clk);
      chk(in_rst, 3'h7);
      @(posedge clk);
      adj_uv <= 1'b0;
      supply_uv <= 1'b0;
      rel(RC, RC + FC + 4);
   endtask
   task automatic t_unconnected;
      @(posedge clk);
      mr_conn <= 1'b0;
      manual_reset_req_n <= 1'b0;
      cyc(4);
      @(negedge clk);
      chk(in_rst, 3'h0);
      chk(asrt, 3'h0);
      @(posedge clk);
      manual_reset_req_n <= 1'b1;
      @(posedge clk);
      mr_conn <= 1'b1;
   endtask
   // power-on reset held for k more cycles, then the full release delay
   task automatic t_power(input int k);
      @(posedge clk);
      reset_n <= 1'b0;
      cyc(k);
      @(negedge clk);
      chk(in_rst, 3'h7);
      @(posedge clk);
      reset_n <= 1'b1;
      rel(RC, RC + FC + 4);
   endtask
   task automatic close_out;
      if (errors == 0 && comparisons > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////
   initial begin
      t_power(4);
      t_manual();
      t_uv(1'b0);
      t_uv(1'b1);
      t_power(2);
      t_unconnected();
      close_out();
   end
   initial begin
      #(25 * 2000);
      errors++;
      close_out();
   end
endmodule
`default_nettype wire
